/* File: hw/plmac_core.sv */
`default_nettype none
`include "plmac_defines.svh"

// Function
// RULE_01: Extreme strap, config low: advertise everything
// RULE_02: Extreme strap, config high: 10 Mbps only
// RULE_03: Middle strap, config low: 100 Mbps only
// RULE_04: Middle strap, config high: both speeds
// RULE_05: Power-up negotiation with parallel detection
// RULE_06: Non-negotiating partner: speed from pulses/idles
// RULE_07: Parallel detect gives half duplex, writable
// RULE_08: MAC side speed follows resolved line
// RULE_09: Registers 0-6 and 16-20, sixteen bits
// RULE_10: Copper 100: scrambled MLT-3, continuous idles
// RULE_11: Copper 10: Manchester, periodic link pulses
// RULE_12: Copper off in power-down, fiber, disconnect
// RULE_13: Fiber: NRZI, no scrambling, no MLT-3
// RULE_14: Fiber forced 100 only, no negotiation
// RULE_15: Fiber invalid conditions take link down
// RULE_16: Fiber off in power-down or copper; low
// RULE_17: Bit 17.3 picks MAC driver strength
// RULE_18: Fixed copper speed and duplex supported
// RULE_19: With negotiation, config input shapes advertisement
// RULE_20: Management-disable high: inputs control continuously
// RULE_21: Strap advertisement stays writable by software
module plmac_core
    import plmac_pkg::*;
#(
    parameter logic [15:0] ID_HI = `PLMAC_ID_HI_VAL, // Arbitrary value
    parameter logic [15:0] ID_LO = `PLMAC_ID_LO_VAL, // Arbitrary value
    parameter int LINK_PULSE_CYCLES = `PLMAC_LINK_PULSE_US * `PLMAC_CLK_MHZ
) (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire plmac_pins_type pins, // Strap and control pins
    input wire plmac_line_in_type line_in, // Line receiver status
    input wire logic [4:0] reg_addr, // Register address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_we, // Write strobe
    input wire logic reg_re, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    output plmac_line_out_type line_out // Line and MAC side controls
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        plmac_pins_type pins_meta;
        plmac_pins_type pins_sync;
        logic loaded;
        logic [1:0] load_wait;
        logic ctrl_speed;
        logic ctrl_anen;
        logic ctrl_pdn;
        logic ctrl_restart;
        logic ctrl_duplex;
        logic [3:0] adv;
        logic [15:0] lpa;
        logic lp_an_able;
        logic drv_reduced;
        logic c19_txdis;
        logic c19_fx;
        logic c19_ltdis;
        plmac_an_state_type an_state;
        logic res_speed;
        logic res_duplex;
        logic [31:0] pulse_cnt;
        logic [15:0] rdata;
        plmac_line_out_type out;
    } plmac_state_type;

    plmac_state_type r;
    plmac_state_type next_r;

    logic extreme;
    logic an_strap;
    logic [3:0] strap_adv;
    logic [3:0] common;
    logic copper_en;
    logic fiber_en;
    logic an_active;
    logic op_speed;
    logic op_duplex;
    logic op_link;

    // ----------------------------------------
    // Strap decode
    // ----------------------------------------
    always_comb begin
        extreme = (r.pins_sync.speed_advertise_strap == 2'h0) ||
                  (r.pins_sync.speed_advertise_strap == 2'h3);
        an_strap = (r.pins_sync.autoneg_enable_strap == 2'h1) ||
                   (r.pins_sync.autoneg_enable_strap == 2'h2);
        // Order {100FD, 100HD, 10FD, 10HD} = bits 4.8..4.5
        if (!an_strap) begin
            strap_adv = `PLMAC_ADV_ALL;
        end else if (extreme && !r.pins_sync.speed_config_input) begin
            strap_adv = `PLMAC_ADV_ALL; // RULE_01
        end else if (extreme) begin
            strap_adv = {2'b00, r.pins_sync.full_duplex_strap, 1'b1}; // RULE_02
        end else if (!r.pins_sync.speed_config_input) begin
            strap_adv = {r.pins_sync.full_duplex_strap, 1'b1, 2'b00}; // RULE_03
        end else begin
            strap_adv = {r.pins_sync.full_duplex_strap, 1'b1,
                         r.pins_sync.full_duplex_strap, 1'b1}; // RULE_04 RULE_19
        end
    end

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    always_comb begin
        copper_en = !r.ctrl_pdn && !r.c19_fx && !r.c19_txdis; // RULE_12
        fiber_en = !r.ctrl_pdn && r.c19_fx; // RULE_16
        an_active = r.ctrl_anen && !r.c19_fx && !r.ctrl_pdn; // RULE_14
        common = r.adv & {r.lpa[8], r.lpa[7], r.lpa[6], r.lpa[5]};
        if (r.c19_fx) begin
            op_speed = 1'b1; // RULE_14
            op_duplex = r.ctrl_duplex;
            op_link = fiber_en && line_in.fx_symbol_ok && !line_in.fx_invalid; // RULE_15
        end else if (an_active) begin
            op_speed = r.res_speed;
            op_duplex = (r.an_state == AN_LINKED_PAR) ? r.ctrl_duplex : r.res_duplex;
            op_link = (r.an_state == AN_LINKED_PAGE) || (r.an_state == AN_LINKED_PAR);
        end else begin
            op_speed = r.ctrl_speed; // RULE_18
            op_duplex = r.ctrl_duplex;
            op_link = copper_en && line_in.copper_signal_ok;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.pins_meta = pins;
        next_r.pins_sync = r.pins_meta;
        next_r.ctrl_restart = 1'b0;
        next_r.out.link_pulse_tx = 1'b0;

        // Straps load once after reset or soft reset, a cycle after sync settles
        next_r.load_wait = {r.load_wait[0], 1'b1};
        if (!r.loaded && r.load_wait[1]) begin
            next_r.loaded = 1'b1;
            next_r.ctrl_anen = an_strap;
            next_r.ctrl_speed = r.pins_sync.forced_speed_input;
            next_r.ctrl_duplex = r.pins_sync.full_duplex_strap;
            next_r.ctrl_pdn = 1'b0;
            next_r.adv = strap_adv;
            next_r.drv_reduced = 1'b0;
            next_r.c19_txdis = 1'b0;
            next_r.c19_fx = !an_strap && !extreme;
            next_r.c19_ltdis = !an_strap && r.pins_sync.speed_config_input;
            next_r.an_state = AN_OFF;
        end

        // Register writes
        if (r.loaded && reg_we) begin
            case (reg_addr)
                `PLMAC_REG_CTRL: begin
                    next_r.loaded = !reg_wdata[`PLMAC_CTRL_RESET];
                    next_r.ctrl_speed = reg_wdata[`PLMAC_CTRL_SPEED];
                    next_r.ctrl_anen = reg_wdata[`PLMAC_CTRL_ANEN];
                    next_r.ctrl_pdn = reg_wdata[`PLMAC_CTRL_PDN];
                    next_r.ctrl_restart = reg_wdata[`PLMAC_CTRL_RESTART];
                    next_r.ctrl_duplex = reg_wdata[`PLMAC_CTRL_DUPLEX]; // RULE_07
                end
                `PLMAC_REG_ADV: begin
                    next_r.adv = reg_wdata[`PLMAC_ADV_LO +: 4]; // RULE_21
                end
                `PLMAC_REG_CFG17: begin
                    next_r.drv_reduced = reg_wdata[`PLMAC_C17_DRV];
                end
                `PLMAC_REG_CFG19: begin
                    next_r.c19_txdis = reg_wdata[`PLMAC_C19_TXDIS];
                    next_r.c19_fx = reg_wdata[`PLMAC_C19_FX];
                    next_r.c19_ltdis = reg_wdata[`PLMAC_C19_LTDIS];
                end
                default: begin
                end
            endcase
        end

        // Hardware control overrides software while management is disabled
        if (r.loaded && r.pins_sync.management_disable_input) begin
            next_r.adv = strap_adv; // RULE_20
            next_r.ctrl_duplex = r.pins_sync.full_duplex_strap;
            next_r.ctrl_speed = r.pins_sync.forced_speed_input;
            if (!r.ctrl_anen) begin
                next_r.c19_ltdis = r.pins_sync.speed_config_input;
            end
        end

        // Negotiation and parallel detection
        case (r.an_state)
            AN_OFF: begin
                if (r.loaded && an_active) begin
                    next_r.an_state = AN_DETECT; // RULE_05
                end
            end
            AN_DETECT: begin
                if (line_in.flp_page_valid) begin
                    next_r.lpa = line_in.partner_page;
                    next_r.lp_an_able = 1'b1;
                    next_r.an_state = AN_LINKED_PAGE; // RULE_05
                end else if (line_in.idle_seen) begin
                    next_r.res_speed = 1'b1; // RULE_06
                    next_r.ctrl_duplex = 1'b0; // RULE_07
                    next_r.lp_an_able = 1'b0;
                    next_r.an_state = AN_LINKED_PAR;
                end else if (line_in.link_pulse_seen) begin
                    next_r.res_speed = 1'b0; // RULE_06
                    next_r.ctrl_duplex = 1'b0; // RULE_07
                    next_r.lp_an_able = 1'b0;
                    next_r.an_state = AN_LINKED_PAR;
                end
            end
            AN_LINKED_PAGE: begin
                // Highest common ability wins
                next_r.res_speed = common[3] || common[2];
                next_r.res_duplex = common[3] || (!common[2] && common[1]);
                if (common == 4'h0 || !line_in.copper_signal_ok) begin
                    next_r.an_state = AN_DETECT;
                end
            end
            AN_LINKED_PAR: begin
                if (!line_in.copper_signal_ok) begin
                    next_r.an_state = AN_DETECT;
                end
            end
            default: begin
                next_r.an_state = AN_OFF;
            end
        endcase
        if (r.loaded && (!an_active || r.ctrl_restart)) begin
            next_r.an_state = an_active ? AN_DETECT : AN_OFF;
        end

        // Link pulse timer for copper 10 Mbps
        if (copper_en && !op_speed && !r.c19_ltdis) begin
            if (r.pulse_cnt >= 32'(LINK_PULSE_CYCLES - 1)) begin
                next_r.pulse_cnt = 32'h0000_0000;
                next_r.out.link_pulse_tx = 1'b1; // RULE_11
            end else begin
                next_r.pulse_cnt = r.pulse_cnt + 32'h0000_0001;
            end
        end else begin
            next_r.pulse_cnt = 32'h0000_0000;
        end

        // Line and MAC side controls
        next_r.out.tp_out_en = copper_en; // RULE_12
        next_r.out.tp_bias_en = copper_en;
        next_r.out.fx_out_en = fiber_en; // RULE_16
        next_r.out.scramble_en = copper_en && op_speed; // RULE_10
        next_r.out.mlt3_en = copper_en && op_speed;
        next_r.out.manchester_en = copper_en && !op_speed; // RULE_11
        next_r.out.nrzi_en = fiber_en; // RULE_13
        next_r.out.mii_speed_100 = op_speed; // RULE_08
        next_r.out.full_duplex = op_duplex;
        next_r.out.link_up = op_link; // RULE_15
        next_r.out.mii_drive_reduced = r.drv_reduced; // RULE_17

        // Register reads, data valid the following cycle
        if (reg_re) begin
            case (reg_addr) // RULE_09
                `PLMAC_REG_CTRL: begin
                    next_r.rdata = 16'h0000;
                    next_r.rdata[`PLMAC_CTRL_SPEED] = r.ctrl_speed;
                    next_r.rdata[`PLMAC_CTRL_ANEN] = r.ctrl_anen;
                    next_r.rdata[`PLMAC_CTRL_PDN] = r.ctrl_pdn;
                    next_r.rdata[`PLMAC_CTRL_RESTART] = r.ctrl_restart;
                    next_r.rdata[`PLMAC_CTRL_DUPLEX] = r.ctrl_duplex;
                end
                `PLMAC_REG_STAT: begin
                    next_r.rdata = `PLMAC_STAT_FIXED;
                    next_r.rdata[`PLMAC_STAT_LINK] = r.out.link_up;
                    next_r.rdata[`PLMAC_STAT_ANCMP] = (r.an_state == AN_LINKED_PAGE) ||
                                                      (r.an_state == AN_LINKED_PAR);
                end
                `PLMAC_REG_ID_HI: next_r.rdata = ID_HI;
                `PLMAC_REG_ID_LO: next_r.rdata = ID_LO;
                `PLMAC_REG_ADV: next_r.rdata = {7'h00, r.adv, 5'h00} | `PLMAC_ADV_SELECTOR;
                `PLMAC_REG_LPA: next_r.rdata = r.lpa;
                `PLMAC_REG_EXP: next_r.rdata = {15'h0000, r.lp_an_able};
                `PLMAC_REG_CFG17: next_r.rdata = {12'h000, r.drv_reduced, 3'h0};
                `PLMAC_REG_CFG19: begin
                    next_r.rdata = 16'h0000;
                    next_r.rdata[`PLMAC_C19_TXDIS] = r.c19_txdis;
                    next_r.rdata[`PLMAC_C19_FX] = r.c19_fx;
                    next_r.rdata[`PLMAC_C19_LTDIS] = r.c19_ltdis;
                end
                `PLMAC_REG_STAT20: begin
                    next_r.rdata = 16'h0000;
                    next_r.rdata[`PLMAC_S20_SPEED] = r.out.mii_speed_100;
                    next_r.rdata[`PLMAC_S20_DUPLEX] = r.out.full_duplex;
                end
                default: next_r.rdata = 16'h0000;
            endcase
        end else begin
            next_r.rdata = 16'h0000;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign line_out = r.out;

endmodule

`default_nettype wire

/* File: hw/plmac_defines.svh */
`ifndef PLMAC_DEFINES_SVH
`define PLMAC_DEFINES_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PLMAC_REG_CTRL 5'h00
`define PLMAC_REG_STAT 5'h01
`define PLMAC_REG_ID_HI 5'h02
`define PLMAC_REG_ID_LO 5'h03
`define PLMAC_REG_ADV 5'h04
`define PLMAC_REG_LPA 5'h05
`define PLMAC_REG_EXP 5'h06
`define PLMAC_REG_R16 5'h10
`define PLMAC_REG_CFG17 5'h11
`define PLMAC_REG_R18 5'h12
`define PLMAC_REG_CFG19 5'h13
`define PLMAC_REG_STAT20 5'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLMAC_CTRL_RESET 15
`define PLMAC_CTRL_SPEED 13
`define PLMAC_CTRL_ANEN 12
`define PLMAC_CTRL_PDN 11
`define PLMAC_CTRL_RESTART 9
`define PLMAC_CTRL_DUPLEX 8
`define PLMAC_STAT_ANCMP 5
`define PLMAC_STAT_LINK 2
`define PLMAC_ADV_LO 5
`define PLMAC_EXP_LP_AN 0
`define PLMAC_C17_DRV 3
`define PLMAC_C19_TXDIS 0
`define PLMAC_C19_FX 2
`define PLMAC_C19_LTDIS 8
`define PLMAC_S20_SPEED 1
`define PLMAC_S20_DUPLEX 0

// ----------------------------------------
// Fixed values and reset values
// ----------------------------------------
`define PLMAC_STAT_FIXED 16'h7809
`define PLMAC_ADV_SELECTOR 16'h0001
`define PLMAC_ADV_ALL 4'hF
`define PLMAC_ID_HI_VAL 16'h0A5A
`define PLMAC_ID_LO_VAL 16'h5A50

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLMAC_CLK_MHZ 200
`define PLMAC_LINK_PULSE_US 16

`endif

/* File: hw/plmac_pkg.sv */
`default_nettype none

package plmac_pkg;

    // Four-level strap code: 0 highest voltage .. 3 lowest
    typedef logic [1:0] plmac_level_type;

    typedef enum logic [2:0] {
        AN_OFF,
        AN_DETECT,
        AN_LINKED_PAGE,
        AN_LINKED_PAR
    } plmac_an_state_type;

    typedef struct packed {
        plmac_level_type speed_advertise_strap;
        plmac_level_type autoneg_enable_strap;
        logic speed_config_input;
        logic full_duplex_strap;
        logic management_disable_input;
        logic forced_speed_input;
    } plmac_pins_type;

    typedef struct packed {
        logic flp_page_valid;
        logic [15:0] partner_page;
        logic link_pulse_seen;
        logic idle_seen;
        logic copper_signal_ok;
        logic fx_symbol_ok;
        logic fx_invalid;
    } plmac_line_in_type;

    typedef struct packed {
        logic tp_out_en;
        logic tp_bias_en;
        logic fx_out_en;
        logic scramble_en;
        logic mlt3_en;
        logic manchester_en;
        logic nrzi_en;
        logic link_pulse_tx;
        logic mii_speed_100;
        logic full_duplex;
        logic link_up;
        logic mii_drive_reduced;
    } plmac_line_out_type;

endpackage

`default_nettype wire

/* File: tb/plmac_core_properties.sv */
`default_nettype none

module plmac_core_properties
    import plmac_pkg::*;
#(
    parameter int LINK_PULSE_CYCLES = 16
) (
    input wire logic sys_clk, // Clock
    input wire logic rstn, // Reset, active low
    input wire plmac_pins_type pins, // Straps
    input wire plmac_line_in_type line_in, // Receiver status
    input wire logic [4:0] reg_addr, // Address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_we, // Write strobe
    input wire logic reg_re, // Read strobe
    input wire logic [15:0] reg_rdata, // Read data
    input wire plmac_line_out_type line_out // Line controls
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Link pulse gap
    // ----------------------------------------
    logic [15:0] pulse_gap;
    // No pulse is owed outside a live 10 Mbps copper link
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_gap <= 16'h0000;
        end else if (line_out.link_pulse_tx || !line_out.manchester_en
                     || !line_out.tp_out_en || !line_out.link_up) begin
            pulse_gap <= 16'h0000;
        end else begin
            pulse_gap <= pulse_gap + 16'h0001;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_rdata_idle;
        !reg_re |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read");
    property p_fx_tp;
        line_out.fx_out_en |-> !line_out.tp_out_en && !line_out.tp_bias_en;
    endproperty
    a_fx_tp: assert property (p_fx_tp)
        else $error("fiber and copper enabled together");
    property p_fx_code;
        line_out.fx_out_en |-> line_out.nrzi_en && !line_out.scramble_en
            && !line_out.mlt3_en && !line_out.manchester_en;
    endproperty
    a_fx_code: assert property (p_fx_code)
        else $error("fiber coding wrong");
    property p_fx_speed;
        line_out.fx_out_en |-> line_out.mii_speed_100;
    endproperty
    a_fx_speed: assert property (p_fx_speed)
        else $error("fiber not at 100");
    property p_fx_bad;
        (line_out.fx_out_en && line_in.fx_invalid) [*3] |-> !line_out.link_up;
    endproperty
    a_fx_bad: assert property (p_fx_bad)
        else $error("fiber link kept on invalid line");
    property p_tx100;
        line_out.mlt3_en |-> line_out.scramble_en && line_out.mii_speed_100
            && !line_out.nrzi_en;
    endproperty
    a_tx100: assert property (p_tx100)
        else $error("copper 100 coding wrong");
    property p_tx10;
        line_out.manchester_en |-> !line_out.mii_speed_100 && !line_out.mlt3_en
            && !line_out.scramble_en;
    endproperty
    a_tx10: assert property (p_tx10)
        else $error("copper 10 coding wrong");
    property p_pulse;
        pulse_gap <= LINK_PULSE_CYCLES + 4;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("link pulse missing");
    property p_drive;
        reg_we && reg_addr == 5'h11 |-> ##2
            line_out.mii_drive_reduced == $past(reg_wdata[3], 2);
    endproperty
    a_drive: assert property (p_drive)
        else $error("driver strength not from write");
    property p_tp_bias;
        line_out.tp_out_en == line_out.tp_bias_en;
    endproperty
    a_tp_bias: assert property (p_tp_bias)
        else $error("copper bias differs from enable");
endmodule

`default_nettype wire

/* File: tb/plmac_partner.sv */
`default_nettype none

module plmac_partner
    import plmac_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic [2:0] mode, // Far-end behaviour
    output plmac_line_in_type line_in // Receiver reports
);
    logic [3:0] tick;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 4'h0;
        end else begin
            tick <= tick + 4'h1;
        end
    end

    // Page shown only with its strobe, inverse otherwise
    always_comb begin
        line_in = '0;
        line_in.partner_page = 16'hFE1E;
        case (mode)
            3'h1: begin
                line_in.flp_page_valid = (tick == 4'h0);
                line_in.partner_page = (tick == 4'h0) ? 16'h01E1 : 16'hFE1E;
                line_in.copper_signal_ok = 1'b1;
            end
            3'h2: begin
                line_in.link_pulse_seen = (tick == 4'h0);
                line_in.copper_signal_ok = 1'b1;
            end
            3'h3: begin
                line_in.idle_seen = 1'b1;
                line_in.copper_signal_ok = 1'b1;
            end
            3'h4: line_in.fx_symbol_ok = 1'b1;
            3'h5: begin
                line_in.fx_symbol_ok = 1'b1;
                line_in.fx_invalid = 1'b1;
            end
            default: ;
        endcase
    end
endmodule

`default_nettype wire

/* File: tb/plmac_core_tb.sv */
`default_nettype none

module plmac_core_tb import plmac_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LP = 16;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    plmac_pins_type pins = '0;
    plmac_line_in_type line_in;
    plmac_line_out_type line_out;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] rd_data;
    logic [2:0] mode = 3'h0;
    int errors = 0;
    int check_count = 0;

    plmac_core #(.LINK_PULSE_CYCLES(LP)) u_plmac_core (.sys_clk, .rstn, .pins, .line_in,
        .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .line_out);
    plmac_partner u_plmac_partner (.sys_clk, .rstn, .mode, .line_in);

    initial forever #2.5 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Bus and helper tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1;
        rd_data = reg_rdata;
    endtask

    task automatic restart(input plmac_pins_type p, input logic [2:0] m);
        @(posedge sys_clk);
        pins <= p;
        mode <= m;
        rstn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic wait_link(input logic v);
        int n = 0;
        while (line_out.link_up !== v && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_adv();
        logic [3:0] e;
        logic ext;
        for (int sp = 0; sp < 4; sp++) begin
            for (int k = 0; k < 4; k++) begin
                ext = (sp == 0 || sp == 3);
                if (ext && !k[1]) e = 4'hF;
                else if (ext) e = {2'b00, k[0], 1'b1};
                else if (!k[1]) e = {k[0], 1'b1, 2'b00};
                else e = {k[0], 1'b1, k[0], 1'b1};
                restart('{sp[1:0], 2'h1, k[1], k[0], 1'b0, 1'b0}, 3'h0);
                rd(5'h04);
                check("adv", rd_data, {7'h00, e, 5'h01});
            end
        end
        $display("t_adv done");
    endtask

    task automatic t_sw();
        restart('{2'h0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h0);
        wr(5'h04, 16'h0021);
        rd(5'h04);
        check("adv written", rd_data, 16'h0021);
        restart('{2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0}, 3'h0);
        wr(5'h04, 16'h0021);
        rd(5'h04);
        check("adv held", rd_data, 16'h01E1);
        @(posedge sys_clk) pins.speed_config_input <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(5'h04);
        check("adv follows pin", rd_data, 16'h0021);
        $display("t_sw done");
    endtask

    task automatic t_regs();
        logic [4:0] holes[4] = '{5'h07, 5'h0F, 5'h15, 5'h1F};
        restart('{2'h0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h0);
        foreach (holes[i]) begin
            wr(holes[i], 16'hFFFF);
            rd(holes[i]);
            check("unmapped", rd_data, 16'h0000);
        end
        rd(5'h01);
        check("status", rd_data & 16'hFFDB, 16'h7809);
        rd(5'h11);
        check("drive reg", rd_data & 16'h0008, 16'h0000);
        check("drive out", {15'h0, line_out.mii_drive_reduced}, 16'h0000);
        wr(5'h11, 16'h0008);
        @(posedge sys_clk);
        #1;
        check("drive set", {15'h0, line_out.mii_drive_reduced}, 16'h0001);
        $display("t_regs done");
    endtask

    task automatic t_par();
        int n = 0;
        restart('{2'h0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h3);
        wait_link(1'b1);
        check("idle det", {12'h0, line_out.mlt3_en, line_out.link_up, line_out.mii_speed_100,
            line_out.full_duplex}, 16'h000E);
        rd(5'h00);
        wr(5'h00, rd_data | 16'h0100);
        settle();
        check("fd later", {15'h0, line_out.full_duplex}, 16'h0001);
        restart('{2'h0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h2);
        wait_link(1'b1);
        check("pulse det", {12'h0, line_out.manchester_en, line_out.link_up,
            line_out.mii_speed_100, line_out.full_duplex}, 16'h000C);
        while (line_out.link_pulse_tx !== 1'b1 && n < 2 * LP + 8) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("pulse tx", {15'h0, line_out.link_pulse_tx}, 16'h0001);
        restart('{2'h0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0}, 3'h1);
        wait_link(1'b1);
        settle();
        check("negotiated", {14'h0, line_out.mii_speed_100, line_out.full_duplex},
            16'h0003);
        rd(5'h06);
        check("partner neg", rd_data & 16'h0001, 16'h0001);
        $display("t_par done");
    endtask

    task automatic t_fx();
        restart('{2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1}, 3'h4);
        wait_link(1'b1);
        check("fiber", {11'h0, line_out.fx_out_en, line_out.tp_out_en, line_out.nrzi_en,
            line_out.mii_speed_100, line_out.link_up}, 16'h0017);
        rd(5'h00);
        check("fiber no neg", rd_data & 16'h1000, 16'h0000);
        @(posedge sys_clk) mode <= 3'h5;
        wait_link(1'b0);
        check("fiber bad", {15'h0, line_out.link_up}, 16'h0000);
        restart('{2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1}, 3'h3);
        wait_link(1'b1);
        check("fixed tx", {11'h0, line_out.fx_out_en, line_out.tp_out_en, line_out.mlt3_en,
            line_out.mii_speed_100, line_out.link_up}, 16'h000F);
        wr(5'h13, 16'h0001);
        settle();
        check("tx disc", {14'h0, line_out.fx_out_en, line_out.tp_out_en}, 16'h0000);
        wr(5'h13, 16'h0000);
        wr(5'h00, 16'h0800);
        settle();
        check("pdn", {14'h0, line_out.fx_out_en, line_out.tp_out_en}, 16'h0000);
        $display("t_fx done");
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        t_adv();
        t_sw();
        t_regs();
        t_par();
        t_fx();
        wrap_up();
    end

    // Whole run is about 500 cycles; allow over twenty-five times that
    initial begin
        #75000;
        errors++;
        wrap_up();
    end
endmodule

bind plmac_core plmac_core_properties #(.LINK_PULSE_CYCLES(LINK_PULSE_CYCLES))
    u_plmac_core_properties (.sys_clk, .rstn, .pins, .line_in, .reg_addr, .reg_wdata,
    .reg_we, .reg_re, .reg_rdata, .line_out);

`default_nettype wire
